/* verilog/scc_pkg.sv */
// package: constants, types and field layout of the serial calendar clock port
package scc_pkg;

  // command word layout (lsb is the direction bit)
  localparam int CMD_BITS = 4;
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_YEAR = 3'h1;
  localparam logic [2:0] SEL_MONTH = 3'h2;
  localparam logic [2:0] SEL_DATE = 3'h3;
  localparam logic [2:0] SEL_WEEKDAY = 3'h4;
  localparam logic [2:0] SEL_HOUR = 3'h5;
  localparam logic [2:0] SEL_MINUTE = 3'h6;
  localparam logic [2:0] SEL_SECOND = 3'h7;
  localparam int WEEKDAY_BITS = 4;
  localparam int FIELD_BITS = 8;

  // field masks for unused high bits
  localparam logic [7:0] MASK_SEC = 8'h7f;
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_YEAR = 8'hff;
  localparam logic [2:0] MASK_WDAY = 3'h7;

  // reset values of the calendar
  localparam logic [7:0] RST_SEC = 8'h00;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h00;
  localparam logic [2:0] RST_WDAY = 3'h1;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // rollover limits in bcd
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [2:0] MAX_WDAY = 3'h7;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [7:0] FEB = 8'h02;

  // oscillator timebase
  localparam int OSC_HZ = 32768;
  localparam int CORE_HZ = 40000000;
  localparam int OSC_PER_SEC = OSC_HZ;
  localparam int PRE_W = 15;
  localparam int CTRL_OSCILLATOR_OUTPUT_PIN_BIT = 7;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [2:0] wday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } scc_time_s;

  typedef struct packed {
    logic load;
    logic [2:0] sel;
    logic [7:0] data;
  } scc_wr_s;

endpackage

/* verilog/scc_bcd_digit.sv */
// bcd two-digit counter with programmable top value and restart value
`timescale 1ns/1ps
module scc_bcd_digit (
  input wire logic [7:0] value,
  input wire logic [7:0] top,
  input wire logic [7:0] first,
  output logic [7:0] next,
  output logic wrap
);
  always_comb begin
    next = value;
    wrap = 1'b0;
    if (value >= top) begin
      next = first;
      wrap = 1'b1;
    end else if (value[3:0] >= 4'h9) begin
      next = {value[7:4] + 4'h1, 4'h0};
    end else begin
      next = {value[7:4], value[3:0] + 4'h1};
    end
  end
endmodule

/* verilog/scc_clock_port.sv */
// serial calendar clock: three-wire port, prescaler and bcd calendar
`timescale 1ns/1ps
// Summary of operation
// (RL1) seconds, minutes 7-bit bcd 0-59; hours 6-bit bcd 0-23; high bits zero
// (RL2) day of month 6-bit bcd 1-31, upper two bits zero
// (RL3) month 5-bit bcd 1-12, upper three bits zero
// (RL4) year full 8-bit bcd 0-99
// (RL5) weekday 3 bits 1-7, fourth bit is the low-supply flag
// (RL6) low-supply flag reads 1 when supply is low, else 0
// (RL7) host writes only valid in-range calendar values
// (RL8) transfers only with chip enable high; data sampled on serial clock rise
// (RL9) first four bits are the command; direction bit 1 means write
// (RL10) write mode halts counting and clears prescaler, except control command
// (RL11) long write frame: first 4 bits command, last 8 or 4 bits data
// (RL12) command and data travel least significant bit first
// (RL13) prescaler restarts when chip enable falls after a write
// (RL14) direction bit 0 selects read; all-zero command is invalid
// (RL15) first serial clock fall after read command turns data pin to output
// (RL16) read sends 8 field bits, or 4 for weekday; later bits invalid
// (RL17) chip enable fall returns data pin to input
// (RL18) reads return live values, no snapshot
// (RL19) chip enable low: data pin released, serial clock ignored
// (RL20) host keeps serial clock low while chip enable changes
// (RL21) select 1..7 picks year..second; select 0 write sets control byte
// (RL22) month lengths and leap years handled automatically
// (RL23) prescaler makes one-second tick; carries ripple up to year
module scc_clock_port (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic oscTick,
  input wire logic lowSupply,
  input wire logic chipEnable,
  input wire logic serialClk,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  output logic oscillatorOutputPin,
  output logic oscillatorOutputOe,
  output logic [6:0] testBits,
  output scc_pkg::scc_time_s timeNow
);
  import scc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [2:0] ceSync_q, ceSync_d;
  logic [2:0] sckSync_q, sckSync_d;
  logic [1:0] dinSync_q, dinSync_d;
  logic [2:0] oscSync_q, oscSync_d;
  logic [1:0] lowSync_q, lowSync_d;
  logic ceHigh, ceFall, sckRise, sckFall, oscRise, dataBit;

  always_comb begin
    ceSync_d = {ceSync_q[1:0], chipEnable};
    sckSync_d = {sckSync_q[1:0], serialClk};
    dinSync_d = {dinSync_q[0], dataIn};
    oscSync_d = {oscSync_q[1:0], oscTick};
    lowSync_d = {lowSync_q[0], lowSupply};
    ceHigh = ceSync_q[1];
    ceFall = ceSync_q[2] & ~ceSync_q[1];
    sckRise = ceHigh & ~sckSync_q[2] & sckSync_q[1]; // see (RL8) (RL19)
    sckFall = ceHigh & sckSync_q[2] & ~sckSync_q[1];
    oscRise = ~oscSync_q[2] & oscSync_q[1];
    dataBit = dinSync_q[1];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ceSync_q <= 3'h0;
      sckSync_q <= 3'h0;
      dinSync_q <= 2'h0;
      oscSync_q <= 3'h0;
      lowSync_q <= 2'h0;
    end else if (clkEn) begin
      ceSync_q <= ceSync_d;
      sckSync_q <= sckSync_d;
      dinSync_q <= dinSync_d;
      oscSync_q <= oscSync_d;
      lowSync_q <= lowSync_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial frame engine
  typedef enum logic [1:0] {S_IDLE, S_CMD, S_WRITE, S_READ} scc_state_e;
  scc_state_e st_q, st_d;
  logic [2:0] cmdCnt_q, cmdCnt_d;
  logic [3:0] cmd_q, cmd_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] rdShift_q, rdShift_d;
  logic [3:0] rdCnt_q, rdCnt_d;
  logic [3:0] wrCnt_q, wrCnt_d;
  logic oe_q, oe_d;
  logic dout_q, dout_d;
  logic rdArmed_q, rdArmed_d;
  logic halt_q, halt_d;
  logic [7:0] fieldRead;
  logic [3:0] cmdNew;
  scc_wr_s wr;
  scc_time_s tm_q;

  always_comb begin
    unique case (cmd_q[3:1])
      SEL_YEAR: fieldRead = tm_q.year & MASK_YEAR;
      SEL_MONTH: fieldRead = tm_q.month & MASK_MONTH;
      SEL_DATE: fieldRead = tm_q.date & MASK_DATE;
      SEL_WEEKDAY: fieldRead = {4'h0, lowSync_q[1], tm_q.wday & MASK_WDAY}; // see (RL5) (RL6)
      SEL_HOUR: fieldRead = tm_q.hour & MASK_HOUR;
      SEL_MINUTE: fieldRead = tm_q.min & MASK_MIN;
      SEL_SECOND: fieldRead = tm_q.sec & MASK_SEC;
      SEL_CTRL: fieldRead = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    cmdCnt_d = cmdCnt_q;
    cmd_d = cmd_q;
    shift_d = shift_q;
    rdShift_d = rdShift_q;
    rdCnt_d = rdCnt_q;
    wrCnt_d = wrCnt_q;
    oe_d = oe_q;
    dout_d = dout_q;
    rdArmed_d = rdArmed_q;
    halt_d = halt_q;
    wr = '{load: 1'b0, sel: cmd_q[3:1], data: shift_q};
    // lsb arrives first, so it ends at bit 0 after the shifts; see (RL12)
    cmdNew = {dataBit, cmd_q[3:1]};
    if (ceFall) begin
      if (st_q == S_WRITE && wrCnt_q != 4'h0) begin // see (RL13) (RL17) (RL19)
        wr.load = 1'b1;
        // weekday keeps the last 4 bits, which sit in the top nibble; see (RL11)
        if (cmd_q[3:1] == SEL_WEEKDAY) begin
          wr.data = {4'h0, shift_q[7:4]};
        end
      end
      st_d = S_IDLE;
      oe_d = 1'b0;
      dout_d = 1'b0;
      halt_d = 1'b0;
      rdArmed_d = 1'b0;
    end else if (!ceHigh) begin
      st_d = S_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          st_d = S_CMD;
          cmdCnt_d = 3'h0;
          wrCnt_d = 4'h0;
          rdCnt_d = 4'h0;
          if (sckRise) begin
            cmd_d = cmdNew;
            cmdCnt_d = 3'h1;
          end
        end
        S_CMD: begin
          if (sckRise) begin
            cmd_d = cmdNew; // see (RL8) (RL9)
            cmdCnt_d = cmdCnt_q + 3'h1;
            if (cmdCnt_q == 3'(CMD_BITS - 1)) begin
              if (cmdNew[0]) begin
                st_d = S_WRITE;
                halt_d = (cmdNew[3:1] != SEL_CTRL); // see (RL10)
              end else if (cmdNew[3:1] != SEL_CTRL) begin
                st_d = S_READ; // see (RL14)
                rdArmed_d = 1'b1;
              end else begin
                st_d = S_WRITE;
                cmd_d = 4'h0;
              end
            end
          end
        end
        S_WRITE: begin
          if (sckRise && cmd_q[0]) begin
            shift_d = {dataBit, shift_q[7:1]}; // see (RL11) (RL12)
            if (wrCnt_q != 4'hf) begin
              wrCnt_d = wrCnt_q + 4'h1;
            end
          end
        end
        S_READ: begin
          if (sckFall) begin
            if (rdArmed_q) begin
              oe_d = 1'b1; // see (RL15) (RL18)
              rdArmed_d = 1'b0;
              rdShift_d = {1'b0, fieldRead[7:1]};
              dout_d = fieldRead[0];
              rdCnt_d = 4'h1;
            end else begin
              dout_d = rdShift_q[0]; // see (RL12) (RL16)
              rdShift_d = {1'b0, rdShift_q[7:1]};
              if (rdCnt_q != 4'hf) begin
                rdCnt_d = rdCnt_q + 4'h1;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_IDLE;
      cmdCnt_q <= 3'h0;
      cmd_q <= 4'h0;
      shift_q <= 8'h00;
      rdShift_q <= 8'h00;
      rdCnt_q <= 4'h0;
      wrCnt_q <= 4'h0;
      oe_q <= 1'b0;
      dout_q <= 1'b0;
      rdArmed_q <= 1'b0;
      halt_q <= 1'b0;
    end else if (clkEn) begin
      st_q <= st_d;
      cmdCnt_q <= cmdCnt_d;
      cmd_q <= cmd_d;
      shift_q <= shift_d;
      rdShift_q <= rdShift_d;
      rdCnt_q <= rdCnt_d;
      wrCnt_q <= wrCnt_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      rdArmed_q <= rdArmed_d;
      halt_q <= halt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and calendar
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic oscillator_output_pin_q, oscillator_output_pin_d;
  scc_time_s tm_d;
  logic secTick;
  logic [7:0] monthDays;
  logic [7:0] secN, minN, hourN, dateN, monN, yearN;
  logic secW, minW, hourW, dateW, monW;
  logic leap;

  always_comb begin
    // year 00 counts as leap; see (RL22)
    leap = (tm_q.year[4] ? (tm_q.year[3:0] == 4'h2 || tm_q.year[3:0] == 4'h6)
                         : (tm_q.year[3:0] == 4'h0 || tm_q.year[3:0] == 4'h4 || tm_q.year[3:0] == 4'h8));
    unique case (tm_q.month)
      FEB: monthDays = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: monthDays = 8'h30;
      default: monthDays = 8'h31;
    endcase
  end

  scc_bcd_digit uSec (.value(tm_q.sec), .top(MAX_SEC), .first(RST_SEC), .next(secN), .wrap(secW));
  scc_bcd_digit uMin (.value(tm_q.min), .top(MAX_SEC), .first(RST_MIN), .next(minN), .wrap(minW));
  scc_bcd_digit uHour (.value(tm_q.hour), .top(MAX_HOUR), .first(RST_HOUR), .next(hourN), .wrap(hourW));
  scc_bcd_digit uDate (.value(tm_q.date), .top(monthDays), .first(RST_DATE), .next(dateN), .wrap(dateW));
  scc_bcd_digit uMon (.value(tm_q.month), .top(MAX_MONTH), .first(RST_MONTH), .next(monN), .wrap(monW));
  scc_bcd_digit uYear (.value(tm_q.year), .top(MAX_YEAR), .first(RST_YEAR), .next(yearN), .wrap());

  always_comb begin
    pre_d = pre_q;
    tm_d = tm_q;
    ctrl_d = ctrl_q;
    secTick = 1'b0;
    oscillator_output_pin_d = oscSync_q[1] & ctrl_q[CTRL_OSCILLATOR_OUTPUT_PIN_BIT];
    if (halt_q) begin
      pre_d = '0; // see (RL10)
    end else if (oscRise) begin
      pre_d = pre_q + PRE_W'(1); // see (RL23)
      secTick = (pre_q == PRE_W'(OSC_PER_SEC - 1));
    end
    if (secTick) begin
      tm_d.sec = secN;
      if (secW) begin
        tm_d.min = minN;
        if (minW) begin
          tm_d.hour = hourN;
          if (hourW) begin
            tm_d.wday = (tm_q.wday >= MAX_WDAY) ? RST_WDAY : tm_q.wday + 3'h1;
            tm_d.date = dateN;
            if (dateW) begin
              tm_d.month = monN;
              if (monW) begin
                tm_d.year = yearN;
              end
            end
          end
        end
      end
    end
    if (wr.load) begin
      // field masks keep unused bits zero; see (RL1) (RL2) (RL3) (RL4) (RL21)
      unique case (wr.sel)
        SEL_CTRL: ctrl_d = wr.data;
        SEL_YEAR: tm_d.year = wr.data & MASK_YEAR;
        SEL_MONTH: tm_d.month = wr.data & MASK_MONTH;
        SEL_DATE: tm_d.date = wr.data & MASK_DATE;
        SEL_WEEKDAY: tm_d.wday = wr.data[2:0] & MASK_WDAY;
        SEL_HOUR: tm_d.hour = wr.data & MASK_HOUR;
        SEL_MINUTE: tm_d.min = wr.data & MASK_MIN;
        SEL_SECOND: tm_d.sec = wr.data & MASK_SEC;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
      ctrl_q <= RST_CTRL;
      oscillator_output_pin_q <= 1'b0;
      tm_q <= '{sec: RST_SEC, min: RST_MIN, hour: RST_HOUR, wday: RST_WDAY,
                date: RST_DATE, month: RST_MONTH, year: RST_YEAR};
    end else if (clkEn) begin
      pre_q <= pre_d;
      ctrl_q <= ctrl_d;
      oscillator_output_pin_q <= oscillator_output_pin_d;
      tm_q <= tm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    dataOut = dout_q;
    dataOe = oe_q;
    oscillatorOutputPin = oscillator_output_pin_q;
    oscillatorOutputOe = ctrl_q[CTRL_OSCILLATOR_OUTPUT_PIN_BIT];
    testBits = ctrl_q[6:0];
    timeNow = tm_q;
  end
endmodule

/* dv/scc_clock_port_asserts.sv */
// concurrent checks on the ports of the serial calendar clock
`timescale 1ns/1ps
module scc_clock_port_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic chipEnable,
  input wire logic dataOe,
  input wire logic oscillatorOutputPin,
  input wire logic oscillatorOutputOe,
  input wire logic [6:0] testBits,
  input wire scc_pkg::scc_time_s timeNow
);
  import scc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_oeRelease;
    (!chipEnable) [*6] |-> !dataOe;
  endproperty
  a_oeRelease: assert property (p_oeRelease) else $error("data pin driven with chip enable low");
  property p_oeRise;
    $rose(dataOe) |-> chipEnable && $past(chipEnable, 4);
  endproperty
  a_oeRise: assert property (p_oeRise) else $error("data pin turned outside a frame");
  property p_secMin;
    timeNow.sec <= MAX_SEC && timeNow.sec[3:0] <= 4'h9 && timeNow.min <= MAX_SEC && timeNow.min[3:0] <= 4'h9;
  endproperty
  a_secMin: assert property (p_secMin) else $error("seconds or minutes out of range");
  property p_hour;
    timeNow.hour <= MAX_HOUR && timeNow.hour[3:0] <= 4'h9;
  endproperty
  a_hour: assert property (p_hour) else $error("hours out of range");
  property p_date;
    timeNow.date >= 8'h01 && timeNow.date <= 8'h31 && timeNow.date[3:0] <= 4'h9;
  endproperty
  a_date: assert property (p_date) else $error("date out of range");
  property p_month;
    timeNow.month >= 8'h01 && timeNow.month <= MAX_MONTH && timeNow.wday != 3'h0;
  endproperty
  a_month: assert property (p_month) else $error("month or weekday out of range");
  property p_secStep;
    $changed(timeNow.sec) |=> $stable(timeNow.sec) [*8];
  endproperty
  a_secStep: assert property (p_secStep) else $error("seconds moved twice in a burst");
  property p_oscillator_output_pin;
    oscillatorOutputPin |-> oscillatorOutputOe || $past(oscillatorOutputOe);
  endproperty
  a_oscillator_output_pin: assert property (p_oscillator_output_pin) else $error("oscillator output active while disabled");
  property p_ctrlStable;
    (!chipEnable) [*6] |=> $stable(testBits) && $stable(oscillatorOutputOe);
  endproperty
  a_ctrlStable: assert property (p_ctrlStable) else $error("control byte changed with chip enable low");
endmodule
bind scc_clock_port scc_clock_port_asserts u_chk (.core_clk(core_clk), .resetn(resetn),
  .chipEnable(chipEnable), .dataOe(dataOe), .oscillatorOutputPin(oscillatorOutputPin),
  .oscillatorOutputOe(oscillatorOutputOe), .testBits(testBits), .timeNow(timeNow));

/* dv/scc_host_model.sv */
// host side of the three-wire serial link
`timescale 1ns/1ps
module scc_host_model (
  input wire logic core_clk,
  input wire logic dataOut,
  input wire logic dataOe,
  output logic chipEnable,
  output logic serialClk,
  output logic dataIn
);
  logic hostBit;
  logic hostOe;
  logic filler = 1'b0;
  logic oeSeen;
  int halfCyc;
  initial begin
    chipEnable = 1'b0;
    serialClk = 1'b0;
    hostBit = 1'b0;
    hostOe = 1'b0;
    oeSeen = 1'b0;
    halfCyc = 4;
  end
  // a released data line shows a pattern that changes every cycle
  always @(posedge core_clk) filler <= ~filler;
  assign dataIn = dataOe ? dataOut : (hostOe ? hostBit : filler);
  task automatic half();
    repeat (halfCyc) begin
      @(posedge core_clk);
      if (dataOe === 1'b1) oeSeen = 1'b1;
    end
  endtask
  task automatic frame(input logic [3:0] cmd, input logic [15:0] wd, input int nw, input int nr,
                       output logic [7:0] rd, output logic sawOe);
    int i;
    rd = 8'h00;
    oeSeen = 1'b0;
    @(posedge core_clk);
    chipEnable <= 1'b1;
    hostOe <= 1'b1;
    for (i = 0; i < 4 + nw + nr; i++) begin
      if (i < 4) hostBit <= cmd[i];
      else if (i < 4 + nw) hostBit <= wd[i - 4];
      else hostOe <= 1'b0;
      half();
      serialClk <= 1'b1;
      half();
      if (i >= 4 + nw) rd[i - 4 - nw] = dataIn;
      serialClk <= 1'b0;
    end
    half();
    chipEnable <= 1'b0;
    hostOe <= 1'b0;
    repeat (8) @(posedge core_clk);
    sawOe = oeSeen;
  endtask
endmodule

/* dv/scc_clock_port_tb.sv */
// self-checking bench of the serial calendar clock port
`timescale 1ns/1ps
module scc_clock_port_tb;
  import scc_pkg::*;
  logic core_clk;
  logic resetn;
  logic clkEn;
  logic oscTick = 1'b0;
  logic lowSupply;
  logic chipEnable;
  logic serialClk;
  logic dataIn;
  logic dataOut;
  logic dataOe;
  logic oscillatorOutputPin;
  logic oscillatorOutputOe;
  logic [6:0] testBits;
  scc_time_s timeNow;
  logic [7:0] rd;
  logic seen;
  int err_total;
  int total_checks;
  scc_clock_port dut (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .oscTick(oscTick),
    .lowSupply(lowSupply), .chipEnable(chipEnable), .serialClk(serialClk), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .oscillatorOutputPin(oscillatorOutputPin),
    .oscillatorOutputOe(oscillatorOutputOe), .testBits(testBits), .timeNow(timeNow));
  scc_host_model host (.core_clk(core_clk), .dataOut(dataOut), .dataOe(dataOe),
    .chipEnable(chipEnable), .serialClk(serialClk), .dataIn(dataIn));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // fast oscillator: one rise every two core clocks
  always @(posedge core_clk) oscTick <= ~oscTick;
  ////////////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] sel, input logic [15:0] v, input int n);
    host.frame({sel, 1'b1}, v, n, 0, rd, seen);
  endtask
  task automatic rdchk(input logic [2:0] sel, input logic [7:0] exp);
    host.frame({sel, 1'b0}, 16'h0000, 0, (sel == SEL_WEEKDAY) ? 4 : 8, rd, seen);
    check8(rd, exp);
    check8({7'h00, seen}, 8'h01);
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(SEL_SECOND, RST_SEC);
    rdchk(SEL_HOUR, RST_HOUR);
    rdchk(SEL_WEEKDAY, {5'h00, RST_WDAY});
    rdchk(SEL_DATE, RST_DATE);
    rdchk(SEL_MONTH, RST_MONTH);
    rdchk(SEL_YEAR, RST_YEAR);
  endtask
  task automatic t_rw();
    logic [2:0] sels [7];
    logic [7:0] vals [7];
    int i;
    sels = '{SEL_YEAR, SEL_MONTH, SEL_DATE, SEL_WEEKDAY, SEL_HOUR, SEL_MINUTE, SEL_SECOND};
    vals = '{8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h30};
    lowSupply <= 1'b1;
    for (i = 0; i < 7; i++) begin
      host.halfCyc = (i % 2) ? 10 : 4;
      wr(sels[i], {8'h00, vals[i]}, (sels[i] == SEL_WEEKDAY) ? 4 : 8);
      rdchk(sels[i], (sels[i] == SEL_WEEKDAY) ? 8'h0f : vals[i]);
    end
    host.halfCyc = 4;
    lowSupply <= 1'b0;
  endtask
  task automatic t_long();
    wr(SEL_SECOND, 16'h045f, 12);
    rdchk(SEL_SECOND, 8'h45);
    wr(SEL_WEEKDAY, 16'h003a, 8);
    rdchk(SEL_WEEKDAY, 8'h03);
  endtask
  // a frame sent while the clock enable is low must leave no trace
  task automatic t_freeze();
    clkEn <= 1'b0;
    wr(SEL_SECOND, 16'h0012, 8);
    clkEn <= 1'b1;
    rdchk(SEL_SECOND, 8'h45);
  endtask
  task automatic t_invalid();
    host.frame(4'h0, 16'h0000, 0, 8, rd, seen);
    check8({7'h00, seen}, 8'h00);
  endtask
  task automatic t_ctrl();
    logic hi;
    logic lo;
    wr(SEL_CTRL, 16'h0085, 8);
    check8({oscillatorOutputOe, testBits}, 8'h85);
    hi = 1'b0;
    lo = 1'b0;
    repeat (8) begin
      @(posedge core_clk);
      hi = hi | (oscillatorOutputPin === 1'b1);
      lo = lo | (oscillatorOutputPin === 1'b0);
    end
    check8({6'h00, hi, lo}, 8'h03);
    wr(SEL_CTRL, 16'h0000, 8);
    check8({oscillatorOutputOe, testBits}, 8'h00);
    hi = 1'b0;
    repeat (8) begin
      @(posedge core_clk);
      hi = hi | (oscillatorOutputPin !== 1'b0);
    end
    check8({7'h00, hi}, 8'h00);
  endtask
  task automatic t_roll();
    wr(SEL_YEAR, 16'h0001, 8);
    wr(SEL_MONTH, 16'h0002, 8);
    wr(SEL_DATE, 16'h0028, 8);
    wr(SEL_HOUR, 16'h0023, 8);
    wr(SEL_MINUTE, 16'h0059, 8);
    wr(SEL_SECOND, 16'h0059, 8);
    // the prescaler restarts from zero at the last chip enable fall
    repeat (2 * OSC_PER_SEC - 700) @(posedge core_clk);
    rdchk(SEL_SECOND, 8'h59);
    repeat (700) @(posedge core_clk);
    rdchk(SEL_SECOND, 8'h00);
    rdchk(SEL_MINUTE, 8'h00);
    rdchk(SEL_HOUR, 8'h00);
    rdchk(SEL_WEEKDAY, 8'h04);
    rdchk(SEL_DATE, 8'h01);
    rdchk(SEL_MONTH, 8'h03);
    rdchk(SEL_YEAR, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    lowSupply = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_rw();
    t_long();
    t_freeze();
    t_invalid();
    t_ctrl();
    t_roll();
    end_of_test();
  end
endmodule
